/* bench/halfword_load_unit_test.sv */
// Purpose: Self-checking bench for the load unit.
// Assumes: Register n holds 1000_0n00 hex, memory holds address xor 8001.
// Notes: Odd addresses fault.
`timescale 1ns/100ps
module halfword_load_unit_test;
   logic        clk_i = 1'b0, nrst_i = 1'b0, issue_i = 1'b0, slow = 1'b0;
   logic        ready_o, illegal_o, mem_req_o, mem_ack_i, mem_fault_i, rf_we_tgt_o, rf_we_base_o, done_o, fault_o;
   logic [31:0] instr_i = 32'h0, rf_rdata_a_i, rf_rdata_b_i, mem_addr_o, rf_wdata_tgt_o, rf_wdata_base_o;
   logic [15:0] mem_rdata_i;
   logic [4:0]  rf_rsel_a_o, rf_rsel_b_o, rf_wsel_tgt_o, rf_wsel_base_o;
   int          failures = 0, num_checks = 0;
   always #25 clk_i = ~clk_i;
   hwl_unit dut_u (.*);
   hwl_mem_model mem_u (.clk_i, .slow_i(slow), .sel_a_i(rf_rsel_a_o), .sel_b_i(rf_rsel_b_o), .val_a_o(rf_rdata_a_i),
      .val_b_o(rf_rdata_b_i), .req_i(mem_req_o), .addr_i(mem_addr_o), .ack_o(mem_ack_i), .data_o(mem_rdata_i),
      .fault_o(mem_fault_i));
   function automatic logic [31:0] gpr(input logic [4:0] n);
      return 32'h1000_0000 | {19'h0, n, 8'h00};
   endfunction
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Kind 1 sign-extends, 2 swaps bytes, 0 zero-extends.
   task automatic load(input logic [31:0] ins, input logic slw, input logic [31:0] ea, input logic upd, input int k);
      int          n;
      logic [15:0] h;
      h = ea[15:0] ^ 16'h8001;
      @(posedge clk_i);
      #1;
      issue_i = 1'b1;
      instr_i = ins;
      slow = slw;
      @(posedge clk_i);
      #1;
      issue_i = 1'b0;
      chk({31'h0, ready_o}, 32'h0);
      for (n = 0; n < 20 && done_o !== 1'b1; n++)
      begin
         @(posedge clk_i);
         #1;
      end
      if (n == 20)
      begin
         failures++;
         $display("MISMATCH %0t no completion", $time);
         conclude();
      end
      chk(mem_addr_o, ea);
      chk({31'h0, ready_o}, 32'h1);
      chk({27'h0, rf_wsel_tgt_o}, {27'h0, ins[25:21]});
      chk({31'h0, fault_o}, {31'h0, ea[0]});
      chk({31'h0, rf_we_tgt_o}, {31'h0, ~ea[0]});
      if (!ea[0])
         chk(rf_wdata_tgt_o, k == 1 ? {{16{h[15]}}, h} : k == 2 ? {16'h0, h[7:0], h[15:8]} : {16'h0, h});
      chk({31'h0, rf_we_base_o}, {31'h0, upd});
      if (upd)
      begin
         chk(rf_wdata_base_o, ea);
         chk({27'h0, rf_wsel_base_o}, {27'h0, ins[20:16]});
      end
   endtask
   task automatic t_idx;
      load({6'h1f, 5'h06, 5'h05, 5'h04, 10'h157, 1'b1}, 1'b0, gpr(5'h05) + gpr(5'h04), 1'b0, 1);
      load({6'h1f, 5'h07, 5'h00, 5'h09, 10'h316, 1'b0}, 1'b1, gpr(5'h09), 1'b0, 2);
      $display("indexed loads done");
   endtask
   task automatic t_disp;
      load({6'h28, 5'h02, 5'h03, 16'hfff0}, 1'b0, gpr(5'h03) - 32'h10, 1'b0, 0);
      load({6'h28, 5'h02, 5'h00, 16'h8002}, 1'b1, 32'hffff_8002, 1'b0, 0);
      $display("displacement loads done");
   endtask
   task automatic t_upd;
      load({6'h29, 5'h02, 5'h08, 16'h0004}, 1'b0, gpr(5'h08) + 32'h4, 1'b1, 0);
      load({6'h29, 5'h08, 5'h08, 16'h0004}, 1'b0, gpr(5'h08) + 32'h4, 1'b0, 0);
      load({6'h1f, 5'h01, 5'h00, 5'h06, 10'h14b, 1'b0}, 1'b0, gpr(5'h06), 1'b0, 0);
      load({6'h1f, 5'h01, 5'h06, 5'h02, 10'h14b, 1'b1}, 1'b1, gpr(5'h06) + gpr(5'h02), 1'b1, 0);
      load({6'h29, 5'h02, 5'h08, 16'h0001}, 1'b0, gpr(5'h08) + 32'h1, 1'b0, 0);
      $display("update loads done");
   endtask
   task automatic t_bad;
      @(posedge clk_i);
      #1;
      issue_i = 1'b1;
      instr_i = 32'hffff_ffff;
      #1;
      chk({31'h0, illegal_o}, 32'h1);
      repeat (3)
      begin
         @(posedge clk_i);
         #1;
         chk({31'h0, mem_req_o}, 32'h0);
      end
      issue_i = 1'b0;
      $display("unknown opcode done");
   endtask
   initial
   begin
      repeat (2) @(posedge clk_i);
      #1;
      nrst_i = 1'b1;
      t_idx();
      t_disp();
      t_upd();
      t_bad();
      conclude();
   end
endmodule

/* bench/hwl_mem_model.sv */
// Purpose: Register file and data memory seen by the load unit.
// Assumes: One request outstanding at a time.
// Notes: Slow mode answers four cycles after the request.
`timescale 1ns/100ps
module hwl_mem_model
(
   input  logic        clk_i,
   input  logic        slow_i,
   input  logic [4:0]  sel_a_i,
   input  logic [4:0]  sel_b_i,
   output logic [31:0] val_a_o,
   output logic [31:0] val_b_o,
   input  logic        req_i,
   input  logic [31:0] addr_i,
   output logic        ack_o,
   output logic [15:0] data_o,
   output logic        fault_o
);
   logic [2:0]  cnt = 3'h0;
   logic [31:0] adr = 32'h0;
   logic [15:0] h;
   assign val_a_o = 32'h1000_0000 | {19'h0, sel_a_i, 8'h00};
   assign val_b_o = 32'h1000_0000 | {19'h0, sel_b_i, 8'h00};
   assign ack_o   = cnt == 3'h1;
   assign h       = adr[15:0] ^ 16'h8001;
   // Outside the answer the bus shows the inverse, so stale data cannot pass.
   assign data_o  = ack_o ? h : ~h;
   assign fault_o = ack_o & adr[0];
   always @(posedge clk_i)
   begin
      cnt <= req_i ? (slow_i ? 3'h4 : 3'h1) : cnt - {2'h0, cnt != 3'h0};
      adr <= req_i ? addr_i : adr;
   end
endmodule

/* bench/hwl_unit_sva.sv */
// Purpose: Port assertions for the load unit.
// Assumes: Memory answers only after a request.
// Notes: Result checks use the word captured when a load is taken.
`timescale 1ns/100ps
module hwl_unit_sva
(
   input logic        clk_i,
   input logic        nrst_i,
   input logic        issue_i,
   input logic [31:0] instr_i,
   input logic        ready_o,
   input logic        illegal_o,
   input logic [4:0]  rf_rsel_a_o,
   input logic [4:0]  rf_rsel_b_o,
   input logic        mem_req_o,
   input logic [31:0] mem_addr_o,
   input logic        mem_ack_i,
   input logic [15:0] mem_rdata_i,
   input logic        mem_fault_i,
   input logic        rf_we_tgt_o,
   input logic [4:0]  rf_wsel_tgt_o,
   input logic [31:0] rf_wdata_tgt_o,
   input logic        rf_we_base_o,
   input logic [4:0]  rf_wsel_base_o,
   input logic [31:0] rf_wdata_base_o,
   input logic        done_o,
   input logic        fault_o
);
   logic [31:0] ins_ff;
   logic        take, alg, brev, upd;
   assign take = ready_o & issue_i & ~illegal_o;
   assign alg  = ins_ff[31:26] == 6'h1f && ins_ff[10:1] == 10'h157;
   assign brev = ins_ff[31:26] == 6'h1f && ins_ff[10:1] == 10'h316;
   assign upd  = ins_ff[31:26] == 6'h29 || ins_ff[31:26] == 6'h1f && ins_ff[10:1] == 10'h14b;
   always_ff @(posedge clk_i or negedge nrst_i)
      if (!nrst_i)
         ins_ff <= 32'h0;
      else if (take)
         ins_ff <= instr_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   property p_sel; rf_rsel_a_o == instr_i[20:16] && rf_rsel_b_o == instr_i[15:11]; endproperty
   a_sel: assert property (p_sel) else $error("read selects wrong");
   property p_take; take |=> mem_req_o ##1 !mem_req_o; endproperty
   a_take: assert property (p_take) else $error("no single request");
   property p_fault; mem_ack_i && mem_fault_i |=> fault_o && !rf_we_tgt_o && !rf_we_base_o; endproperty
   a_fault: assert property (p_fault) else $error("fault not honoured");
   property p_alg; rf_we_tgt_o && alg |-> rf_wdata_tgt_o == {{16{$past(mem_rdata_i[15])}}, $past(mem_rdata_i)};
   endproperty
   a_alg: assert property (p_alg) else $error("sign extension wrong");
   property p_brev; rf_we_tgt_o && brev |-> rf_wdata_tgt_o[31:16] == 16'h0
      && {rf_wdata_tgt_o[7:0], rf_wdata_tgt_o[15:8]} == $past(mem_rdata_i); endproperty
   a_brev: assert property (p_brev) else $error("byte swap wrong");
   property p_zero; rf_we_tgt_o && !alg && !brev |-> rf_wdata_tgt_o == {16'h0, $past(mem_rdata_i)}; endproperty
   a_zero: assert property (p_zero) else $error("zero extension wrong");
   property p_wb; rf_we_base_o |-> rf_wsel_base_o != 5'h0 && rf_wsel_base_o != rf_wsel_tgt_o
      && rf_wdata_base_o == mem_addr_o; endproperty
   a_wb: assert property (p_wb) else $error("bad base write");
   property p_upd; done_o && !fault_o && upd && ins_ff[20:16] != 5'h0 && ins_ff[20:16] != ins_ff[25:21]
      |-> rf_we_base_o && rf_wsel_base_o == ins_ff[20:16]; endproperty
   a_upd: assert property (p_upd) else $error("base write missing");
endmodule
bind hwl_unit hwl_unit_sva sva_u (.*);

/* design/hwl_decode.sv */
// Purpose: Decode of a halfword load word into kind, fields and address.
// Assumes: Register values arrive combinationally over the interface.
// Notes: Purely combinational; the top registers the outcome.
`timescale 1ns/100ps
`include "hwl_defs.svh"
module hwl_decode
(
   input  wire logic [31:0]      instr_i,
   hwl_gpr_if.dec                gpr,
   output hwl_pkg::hwl_kind_t    kind_o,
   output logic [4:0]            tgt_o,
   output logic [4:0]            base_o,
   output logic [31:0]           addr_o
);
   logic [5:0]  op;
   logic [9:0]  xo;
   logic        indexed;
   logic [31:0] offset;
   logic [31:0] base_term;

   assign op = instr_i[`HWL_OP_HI:`HWL_OP_LO];
   assign xo = instr_i[`HWL_XO_HI:`HWL_XO_LO];
   assign tgt_o = instr_i[`HWL_TGT_HI:`HWL_TGT_LO];
   assign base_o = instr_i[`HWL_BASE_HI:`HWL_BASE_LO];
   assign gpr.base_sel = base_o;
   assign gpr.idx_sel = instr_i[`HWL_IDX_HI:`HWL_IDX_LO];

   always_comb
   begin
      kind_o = hwl_pkg::HWL_K_NONE;
      if (op == `HWL_OP_LHZ)
      begin
         kind_o = hwl_pkg::HWL_K_Z_DISP;
      end
      else if (op == `HWL_OP_LHZU)
      begin
         kind_o = hwl_pkg::HWL_K_ZU_DISP;
      end
      else if (op == `HWL_OP_EXT)
      begin
         if (xo == `HWL_XO_ALG_IDX)
         begin
            kind_o = hwl_pkg::HWL_K_ALG_IDX;
         end
         else if (xo == `HWL_XO_BREV_IDX)
         begin
            kind_o = hwl_pkg::HWL_K_BREV_IDX;
         end
         else if (xo == `HWL_XO_ZU_IDX)
         begin
            kind_o = hwl_pkg::HWL_K_ZU_IDX;
         end
      end
   end

   assign indexed = (op == `HWL_OP_EXT);
   // The displacement is sign-extended from sixteen bits.
   assign offset = indexed ? gpr.idx_val
                 : {{16{instr_i[`HWL_DISP_HI]}}, instr_i[`HWL_DISP_HI:`HWL_DISP_LO]};
   // A base field of zero means the value zero, not register zero.
   assign base_term = (base_o == 5'h00) ? 32'h0000_0000 : gpr.base_val;
   assign addr_o = base_term + offset;
endmodule

/* design/hwl_defs.svh */
// Purpose: Constants for the halfword load unit.
// Assumes: Big-endian bit numbering, bit 0 is the most significant bit.
// Notes: Field positions are given as little-endian vector indices.
`ifndef HWL_DEFS_SVH
`define HWL_DEFS_SVH
`define HWL_OP_HI          31
`define HWL_OP_LO          26
`define HWL_TGT_HI         25
`define HWL_TGT_LO         21
`define HWL_BASE_HI        20
`define HWL_BASE_LO        16
`define HWL_IDX_HI         15
`define HWL_IDX_LO         11
`define HWL_XO_HI          10
`define HWL_XO_LO          1
`define HWL_DISP_HI        15
`define HWL_DISP_LO        0
`define HWL_OP_EXT         6'h1f
`define HWL_OP_LHZ         6'h28
`define HWL_OP_LHZU        6'h29
`define HWL_XO_ALG_IDX     10'h157
`define HWL_XO_BREV_IDX    10'h316
`define HWL_XO_ZU_IDX      10'h14b
`endif

/* design/hwl_gpr_if.sv */
// Purpose: Read ports of the register file between decoder and top.
// Assumes: Reads return data in the same cycle.
// Notes: Two read ports, base and index; the displacement comes from the instruction word.
`timescale 1ns/100ps
interface hwl_gpr_if;
   logic [4:0]  base_sel;
   logic [4:0]  idx_sel;
   logic [31:0] base_val;
   logic [31:0] idx_val;
   modport dec
   (
      output base_sel,
      output idx_sel,
      input  base_val,
      input  idx_val
   );
   modport rf
   (
      input  base_sel,
      input  idx_sel,
      output base_val,
      output idx_val
   );
endinterface

/* design/hwl_pkg.sv */
// Purpose: Types for the halfword load unit.
// Assumes: Nothing beyond the constants header.
// Notes: Holds the operation kinds and state layouts.
package hwl_pkg;
   typedef enum logic [2:0] {
      HWL_K_NONE,
      HWL_K_ALG_IDX,
      HWL_K_BREV_IDX,
      HWL_K_Z_DISP,
      HWL_K_ZU_DISP,
      HWL_K_ZU_IDX
   } hwl_kind_t;

   typedef enum logic [1:0] {
      HWL_S_IDLE,
      HWL_S_READ,
      HWL_S_WAIT
   } hwl_state_t;

   typedef struct packed {
      hwl_state_t state;
      hwl_kind_t  kind;
      logic [4:0] tgt;
      logic [4:0] base;
      logic       upd;
      logic [31:0] addr;
      logic        mem_req;
      logic        wb_tgt;
      logic [31:0] wb_tgt_data;
      logic        wb_base;
      logic [31:0] wb_base_data;
      logic        done;
      logic        fault;
   } hwl_st_t;
endpackage

/* design/hwl_unit.sv */
// Purpose: Executes halfword loads: decode, address, memory read, write-back.
// Assumes: Memory answers with mem_ack_i and mem_fault_i after a request.
// Notes: Never touches the exception register or condition field zero.
`timescale 1ns/100ps
`include "hwl_defs.svh"
module hwl_unit
(
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        issue_i,
   input  wire logic [31:0] instr_i,
   output logic             ready_o,
   output logic             illegal_o,
   output logic [4:0]       rf_rsel_a_o,
   output logic [4:0]       rf_rsel_b_o,
   input  wire logic [31:0] rf_rdata_a_i,
   input  wire logic [31:0] rf_rdata_b_i,
   output logic             mem_req_o,
   output logic [31:0]      mem_addr_o,
   input  wire logic        mem_ack_i,
   input  wire logic [15:0] mem_rdata_i,
   input  wire logic        mem_fault_i,
   output logic             rf_we_tgt_o,
   output logic [4:0]       rf_wsel_tgt_o,
   output logic [31:0]      rf_wdata_tgt_o,
   output logic             rf_we_base_o,
   output logic [4:0]       rf_wsel_base_o,
   output logic [31:0]      rf_wdata_base_o,
   output logic             done_o,
   output logic             fault_o
);
   hwl_gpr_if gpr ();
   hwl_pkg::hwl_kind_t kind;
   logic [4:0]         tgt;
   logic [4:0]         base;
   logic [31:0]        addr;
   hwl_pkg::hwl_st_t   st_ff;
   hwl_pkg::hwl_st_t   nxt_st;

   hwl_decode u_dec
   (
      .instr_i (instr_i),
      .gpr     (gpr),
      .kind_o  (kind),
      .tgt_o   (tgt),
      .base_o  (base),
      .addr_o  (addr)
   );

   assign rf_rsel_a_o = gpr.base_sel;
   assign rf_rsel_b_o = gpr.idx_sel;
   assign gpr.base_val = rf_rdata_a_i;
   assign gpr.idx_val = rf_rdata_b_i;

   // Memory halfword arrives with its bit 0 as vector bit 15.
   function automatic logic [31:0] shape(input hwl_pkg::hwl_kind_t k, input logic [15:0] hw);
      logic [31:0] r;
      r = {16'h0000, hw};
      if (k == hwl_pkg::HWL_K_ALG_IDX)
      begin
         r = {{16{hw[15]}}, hw};
      end
      else if (k == hwl_pkg::HWL_K_BREV_IDX)
      begin
         r = {16'h0000, hw[7:0], hw[15:8]};
      end
      return r;
   endfunction

   assign ready_o = (st_ff.state == hwl_pkg::HWL_S_IDLE);
   assign illegal_o = issue_i && ready_o && (kind == hwl_pkg::HWL_K_NONE);
   assign mem_req_o = st_ff.mem_req;
   assign mem_addr_o = st_ff.addr;
   assign rf_we_tgt_o = st_ff.wb_tgt;
   assign rf_wsel_tgt_o = st_ff.tgt;
   assign rf_wdata_tgt_o = st_ff.wb_tgt_data;
   assign rf_we_base_o = st_ff.wb_base;
   assign rf_wsel_base_o = st_ff.base;
   assign rf_wdata_base_o = st_ff.wb_base_data;
   assign done_o = st_ff.done;
   assign fault_o = st_ff.fault;

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.mem_req = 1'b0;
      nxt_st.wb_tgt = 1'b0;
      nxt_st.wb_base = 1'b0;
      nxt_st.done = 1'b0;
      nxt_st.fault = 1'b0;
      unique case (st_ff.state)
         hwl_pkg::HWL_S_IDLE:
         begin
            if (issue_i && kind != hwl_pkg::HWL_K_NONE)
            begin
               nxt_st.kind = kind;
               nxt_st.tgt = tgt;
               nxt_st.base = base;
               nxt_st.addr = addr;
               nxt_st.upd = (kind == hwl_pkg::HWL_K_ZU_DISP) || (kind == hwl_pkg::HWL_K_ZU_IDX);
               nxt_st.mem_req = 1'b1;
               nxt_st.state = hwl_pkg::HWL_S_READ;
            end
         end
         hwl_pkg::HWL_S_READ:
         begin
            nxt_st.state = hwl_pkg::HWL_S_WAIT;
            if (mem_ack_i)
            begin
               nxt_st.state = hwl_pkg::HWL_S_IDLE;
            end
         end
         hwl_pkg::HWL_S_WAIT:
         begin
            if (mem_ack_i)
            begin
               nxt_st.state = hwl_pkg::HWL_S_IDLE;
            end
         end
      endcase
      // A fault cancels both write-backs; the interrupt logic lives outside.
      if (st_ff.state != hwl_pkg::HWL_S_IDLE && mem_ack_i)
      begin
         nxt_st.done = 1'b1;
         nxt_st.fault = mem_fault_i;
         nxt_st.wb_tgt = !mem_fault_i;
         nxt_st.wb_tgt_data = shape(st_ff.kind, mem_rdata_i);
         nxt_st.wb_base = st_ff.upd && !mem_fault_i && (st_ff.base != 5'h00)
                          && (st_ff.base != st_ff.tgt);
         nxt_st.wb_base_data = st_ff.addr;
      end
   end
   // No exception or condition register port exists, so none can change.

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_ff <= '{state: hwl_pkg::HWL_S_IDLE, kind: hwl_pkg::HWL_K_NONE, default: '0};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end
endmodule
